/* core/ees_pkg.sv */
`default_nettype none

package ees_pkg;

  // clock and program cycle timing
  localparam int CLK_MHZ = 100;
  localparam int PROGRAM_CYCLE_TIME_MS = 10;
  // longest time: rounds down (exact here)
  localparam int PROG_CYCLES = PROGRAM_CYCLE_TIME_MS * 1000 * CLK_MHZ;
  localparam int PROG_CNT_W = 20;

  // array and page geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int PAGE_W = 6;
  localparam logic [5:0] PAGE_LAST = 6'h3f;
  localparam int FIFO_W = ADDR_W + DATA_W;
  localparam int FIFO_DEPTH = 8;

  // slave address byte
  localparam logic [4:0] DEV_CODE = 5'h14;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  // synchroniser order {scl, sda, wp, sel1, sel0}; idle bus reads high
  localparam logic [4:0] SYNC_IDLE = 5'h18;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK, ST_WAIT
  } ees_bus_e;

  typedef enum logic [1:0] {
    PH_DEV, PH_AHI, PH_ALO, PH_DATA
  } ees_phase_e;

  typedef enum logic [1:0] {
    PG_OFF, PG_FLUSH, PG_COPY, PG_HOLD
  } ees_prog_e;

endpackage

`default_nettype wire

/* core/ees_eeprom.sv */
`timescale 1ns/1ps
`default_nettype none

module ees_fifo #(
  parameter int W = 23,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ees_fifo_s;

  ees_fifo_s r_r;
  ees_fifo_s r_nxt;
  logic push;
  logic pop;

  assign in_ready = r_r.cnt != (AW+1)'(DEPTH);
  assign out_valid = r_r.cnt != '0;
  assign out_data = r_r.mem[r_r.rp];

  // pointers wrap naturally: depth is a power of two
  always_comb begin
    r_nxt = r_r;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      r_nxt.mem[r_r.wp] = in_data;
      r_nxt.wp = r_r.wp + 1'b1;
    end
    if (pop) begin
      r_nxt.rp = r_r.rp + 1'b1;
    end
    if (push && !pop) begin
      r_nxt.cnt = r_r.cnt + 1'b1;
    end else if (pop && !push) begin
      r_nxt.cnt = r_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////

// Notes on behaviour
// - ignore bus until a start is seen
// - start/stop: sda edge while scl high
// - sda change with scl high is start/stop
// - address top bits must be 10100
// - next two bits match select pins
// - address lsb: 1 read, 0 write
// - matching address acked, then read/write
// - receiver pulls sda low on ninth pulse
// - every written byte is acknowledged unless write protect is high
// - read: send byte, nack ends sending
// - two address bytes load the pointer
// - stop after data starts programming, silent
// - page holds up to 64 bytes
// - write increments six low pointer bits
// - over 64 bytes wraps and overwrites
// - program cycle ends within 10 ms
// - while programming sda released, address ignored
// - busy means no ack to polling
// - write protect high makes array read-only
// - open select pins count as zero
// - protected: refuse first data byte
// - pointer holds last address plus one
// - reads increment whole pointer, wrapping
module ees_eeprom #(
  parameter int PROG_CYCLES = ees_pkg::PROG_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // straps and protection
  input wire logic wp_i,
  input wire logic device_select_bit0,
  input wire logic device_select_bit1,
  // status
  output logic prog_busy
);
  localparam logic [ees_pkg::PROG_CNT_W-1:0] PCNT_LAST =
    ees_pkg::PROG_CNT_W'(PROG_CYCLES - 1);

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] f;
    ees_pkg::ees_bus_e st;
    ees_pkg::ees_phase_e ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic mack;
    logic [ees_pkg::ADDR_W-1:0] ptr;
    logic wrote;
    ees_pkg::ees_prog_e pg;
    logic [ees_pkg::PROG_CNT_W-1:0] pcnt;
    logic [ees_pkg::PAGE_W-1:0] cidx;
    logic [63:0] pv;
    logic [8:0] phi;
    logic sda_o;
    logic sda_oe;
    logic busy;
  } ees_state_s;

  ees_state_s r_r;
  ees_state_s r_nxt;

  logic [7:0] mem [32768];
  logic [7:0] pbuf [64];

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic sda_in;
  logic wp_on;
  logic dev_hit;
  logic byte_done;
  logic load;
  logic ack;
  logic [7:0] rd_byte;
  logic fin_valid;
  logic fin_ready;
  logic fout_valid;
  logic fout_ready;
  logic [ees_pkg::FIFO_W-1:0] fout_data;
  logic buf_we;
  logic arr_we;

  assign sda_o = r_r.sda_o;
  assign sda_oe = r_r.sda_oe;
  assign prog_busy = r_r.busy;
  assign rd_byte = mem[r_r.ptr];

  ////////////////////////////////////////////////////////////////////////////

  // write data path between the bit shifter and the page buffer
  ees_fifo #(
    .W(ees_pkg::FIFO_W),
    .DEPTH(ees_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(fin_valid),
    .in_data({r_r.ptr, r_r.sh}),
    .in_ready(fin_ready),
    .out_valid(fout_valid),
    .out_data(fout_data),
    .out_ready(fout_ready)
  );

  // drain stalls while the page is being programmed
  assign fout_ready = (r_r.pg == ees_pkg::PG_OFF) ||
                      (r_r.pg == ees_pkg::PG_FLUSH);
  assign buf_we = fout_valid && fout_ready;
  assign arr_we = (r_r.pg == ees_pkg::PG_COPY) && r_r.pv[r_r.cidx];

  // page buffer, later bytes overwrite same slot
  always_ff @(posedge clk) begin
    if (buf_we) begin
      pbuf[fout_data[13:8]] <= fout_data[7:0];
    end
    if (arr_we) begin
      mem[{r_r.phi, r_r.cidx}] <= pbuf[r_r.cidx];
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    r_nxt = r_r;
    load = 1'b0;
    ack = 1'b0;
    r_nxt.s1 = {scl_i, sda_i, wp_i, device_select_bit1, device_select_bit0};
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    // a level counts once the second and third stages agree
    r_nxt.f = (~(r_r.s2 ^ r_r.s3) & r_r.s3) | ((r_r.s2 ^ r_r.s3) & r_r.f);
    scl_rise = r_nxt.f[4] && !r_r.f[4];
    scl_fall = !r_nxt.f[4] && r_r.f[4];
    // sda moving under high scl is start or stop
    start_ev = r_r.f[4] && r_nxt.f[4] && r_r.f[3] && !r_nxt.f[3];
    stop_ev = r_r.f[4] && r_nxt.f[4] && !r_r.f[3] && r_nxt.f[3];
    sda_in = r_r.f[3];
    wp_on = r_r.f[2];
    // device code, select pins, pins pulled low outside
    dev_hit = (r_r.sh[7:3] == ees_pkg::DEV_CODE) &&
              (r_r.sh[2:1] == r_r.f[1:0]) && !r_r.busy;
    byte_done = scl_fall && (r_r.st == ees_pkg::ST_RX) &&
                (r_r.cnt == ees_pkg::BITS_PER_BYTE);
    fin_valid = byte_done && (r_r.ph == ees_pkg::PH_DATA) && !wp_on;

    // a start arms the receiver; ignored while programming
    if (start_ev) begin
      if (!r_r.busy) begin
        r_nxt.st = ees_pkg::ST_RX;
        r_nxt.ph = ees_pkg::PH_DEV;
        r_nxt.cnt = '0;
        r_nxt.sda_oe = 1'b0;
        r_nxt.wrote = 1'b0;
        r_nxt.pv = '0;
      end
    end else if (stop_ev) begin
      r_nxt.st = ees_pkg::ST_IDLE;
      r_nxt.sda_oe = 1'b0;
      // program cycle starts on stop after written data
      if (r_r.wrote) begin
        r_nxt.wrote = 1'b0;
        r_nxt.pg = ees_pkg::PG_FLUSH;
        r_nxt.busy = 1'b1;
        r_nxt.pcnt = '0;
      end
    end else begin
      unique case (r_r.st)
        ees_pkg::ST_IDLE, ees_pkg::ST_WAIT: begin
        end
        ees_pkg::ST_RX: begin
          if (scl_rise && r_r.cnt != ees_pkg::BITS_PER_BYTE) begin
            r_nxt.sh = {r_r.sh[6:0], sda_in};
            r_nxt.cnt = r_r.cnt + 4'h1;
          end else if (byte_done) begin
            unique case (r_r.ph)
              ees_pkg::PH_DEV: begin
                if (dev_hit) begin
                  ack = 1'b1;
                  r_nxt.rw = r_r.sh[0];
                  r_nxt.ph = ees_pkg::PH_AHI;
                end
              end
              ees_pkg::PH_AHI: begin
                ack = 1'b1;
                r_nxt.ptr[14:8] = r_r.sh[6:0];
                r_nxt.ph = ees_pkg::PH_ALO;
              end
              ees_pkg::PH_ALO: begin
                ack = 1'b1;
                r_nxt.ptr[7:0] = r_r.sh;
                r_nxt.ph = ees_pkg::PH_DATA;
              end
              ees_pkg::PH_DATA: begin
                // protected array, first data byte refused
                if (!wp_on && fin_ready) begin
                  // data byte acked, page offset steps
                  ack = 1'b1;
                  r_nxt.wrote = 1'b1;
                  r_nxt.ptr[5:0] = r_r.ptr[5:0] + 6'h1;
                end
              end
            endcase
            if (ack) begin
              // pull sda low for the ninth pulse
              r_nxt.st = ees_pkg::ST_ACK;
              r_nxt.sda_oe = 1'b1;
            end else begin
              r_nxt.st = ees_pkg::ST_WAIT;
            end
          end
        end
        ees_pkg::ST_ACK: begin
          if (scl_fall) begin
            r_nxt.sda_oe = 1'b0;
            if (r_r.rw) begin
              load = 1'b1;
            end else begin
              r_nxt.st = ees_pkg::ST_RX;
              r_nxt.cnt = '0;
            end
          end
        end
        ees_pkg::ST_TX: begin
          if (scl_fall) begin
            // release after eight bits for master ack
            if (r_r.cnt == ees_pkg::LAST_TX_BIT) begin
              r_nxt.sda_oe = 1'b0;
              r_nxt.st = ees_pkg::ST_RACK;
            end else begin
              r_nxt.sh = {r_r.sh[6:0], 1'b0};
              r_nxt.cnt = r_r.cnt + 4'h1;
              r_nxt.sda_oe = !r_r.sh[6];
            end
          end
        end
        ees_pkg::ST_RACK: begin
          if (scl_rise) begin
            r_nxt.mack = !sda_in;
          end
          if (scl_fall) begin
            if (r_r.mack) begin
              load = 1'b1;
            end else begin
              r_nxt.st = ees_pkg::ST_WAIT;
            end
          end
        end
      endcase
    end

    // pointer ends one past the byte sent, full wrap
    if (load) begin
      r_nxt.st = ees_pkg::ST_TX;
      r_nxt.sh = rd_byte;
      r_nxt.cnt = '0;
      r_nxt.sda_oe = !rd_byte[7];
      r_nxt.ptr = r_r.ptr + 15'h1;
    end

    if (buf_we) begin
      r_nxt.pv[fout_data[13:8]] = 1'b1;
      r_nxt.phi = fout_data[22:14];
    end

    // flush, copy page, hold out the full program time
    if (r_r.pg != ees_pkg::PG_OFF) begin
      r_nxt.pcnt = r_r.pcnt + 1'b1;
    end
    unique case (r_r.pg)
      ees_pkg::PG_OFF: begin
      end
      ees_pkg::PG_FLUSH: begin
        if (!fout_valid) begin
          r_nxt.pg = ees_pkg::PG_COPY;
          r_nxt.cidx = '0;
        end
      end
      ees_pkg::PG_COPY: begin
        r_nxt.cidx = r_r.cidx + 6'h1;
        if (r_r.cidx == ees_pkg::PAGE_LAST) begin
          r_nxt.pg = ees_pkg::PG_HOLD;
        end
      end
      ees_pkg::PG_HOLD: begin
        // polls are acked again once this clears
        if (r_r.pcnt == PCNT_LAST) begin
          r_nxt.pg = ees_pkg::PG_OFF;
          r_nxt.busy = 1'b0;
          r_nxt.pv = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_r <= '0;
      r_r.s1 <= ees_pkg::SYNC_IDLE;
      r_r.s2 <= ees_pkg::SYNC_IDLE;
      r_r.s3 <= ees_pkg::SYNC_IDLE;
      r_r.f <= ees_pkg::SYNC_IDLE;
    end else begin
      r_r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  arm_on_start_a: assert property (
    r_r.st == ees_pkg::ST_IDLE && !start_ev |=> r_r.st == ees_pkg::ST_IDLE)
    else $error("left idle without a start");

  stop_release_a: assert property (
    stop_ev |=> r_r.st == ees_pkg::ST_IDLE && !r_r.sda_oe)
    else $error("stop did not end the transfer");

  dev_code_a: assert property (
    byte_done && r_r.ph == ees_pkg::PH_DEV &&
    r_r.sh[7:3] != ees_pkg::DEV_CODE |=> r_r.st == ees_pkg::ST_WAIT)
    else $error("foreign device code acknowledged");

  sel_match_a: assert property (
    byte_done && r_r.ph == ees_pkg::PH_DEV &&
    r_r.sh[2:1] != r_r.f[1:0] |=> !r_r.sda_oe)
    else $error("select mismatch acknowledged");

  dir_bit_a: assert property (
    byte_done && r_r.ph == ees_pkg::PH_DEV && dev_hit
    |=> r_r.st == ees_pkg::ST_ACK && r_r.rw == $past(r_r.sh[0]))
    else $error("direction bit not taken");

  ack_drive_a: assert property (
    r_r.st == ees_pkg::ST_ACK |-> r_r.sda_oe && !r_r.sda_o)
    else $error("ack slot not driven low");

  read_nack_a: assert property (
    r_r.st == ees_pkg::ST_RACK && scl_fall && !r_r.mack
    |=> r_r.st == ees_pkg::ST_WAIT [*2])
    else $error("sending went on after nack");

  prog_start_a: assert property (
    stop_ev && r_r.wrote |=> r_r.busy ##1 r_r.busy)
    else $error("program cycle did not start");

  page_step_a: assert property (
    byte_done && r_r.ph == ees_pkg::PH_DATA &&
    r_nxt.st == ees_pkg::ST_ACK
    |=> r_r.ptr[14:6] == $past(r_r.ptr[14:6]) &&
        r_r.ptr[5:0] == $past(r_r.ptr[5:0]) + 6'h1)
    else $error("page pointer step wrong");

  prog_len_a: assert property (
    r_r.pg == ees_pkg::PG_HOLD && r_r.pcnt == PCNT_LAST |=> !r_r.busy)
    else $error("program cycle overran");

  busy_quiet_a: assert property (
    r_r.busy |-> !r_r.sda_oe && r_r.st == ees_pkg::ST_IDLE)
    else $error("bus active while programming");

  wp_refuse_a: assert property (
    byte_done && r_r.ph == ees_pkg::PH_DATA && r_r.f[2]
    |=> r_r.st == ees_pkg::ST_WAIT && !r_r.sda_oe)
    else $error("protected data byte acknowledged");

  seq_step_a: assert property (
    load |=> r_r.ptr == $past(r_r.ptr) + 15'h1)
    else $error("read pointer step wrong");

  write_ack_c: cover property (
    byte_done && r_r.ph == ees_pkg::PH_DATA && r_nxt.st == ees_pkg::ST_ACK);
  read_load_c: cover property (load ##1 r_r.st == ees_pkg::ST_TX);
  prog_done_c: cover property ($fell(r_r.busy));
  wp_nack_c: cover property (byte_done && r_r.ph == ees_pkg::PH_DATA &&
    r_r.f[2]);
endmodule

`default_nettype wire

/* verif/ees_master.sv */
`timescale 1ns/1ps
`default_nettype none

// behavioural two-wire bus master; Q clk cycles per start/stop phase
// a data bit is 8 clk (80 ns): 6 low, 2 high, so the slave's 4-clk
// synchroniser delay still lands its drive inside the low phase
module ees_master #(
  parameter int Q = 6
) (
  // clock
  input wire logic clk,
  // resolved data wire
  input wire logic sda,
  // open-drain drives, high means released
  output logic scl_m,
  output logic sda_m
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end

  task automatic q();
    repeat (Q) @(posedge clk);
  endtask

  // start only from idle or as repeated start
  task automatic start();
    sda_m <= 1'b1;
    q();
    scl_m <= 1'b1;
    q();
    sda_m <= 1'b0;
    q();
    scl_m <= 1'b0;
    q();
  endtask

  // data moves only while clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_m <= b;
    repeat (4) @(posedge clk);
    scl_m <= 1'b1;
    @(posedge clk);
    r = sda;
    @(posedge clk);
    scl_m <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // byte msb first, ack read on ninth pulse
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // master acks to ask for more, nacks to end
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~more, r);
  endtask

  task automatic stop();
    sda_m <= 1'b0;
    q();
    scl_m <= 1'b1;
    q();
    sda_m <= 1'b1;
    q();
    q();
  endtask
endmodule

`default_nettype wire

/* verif/ees_eeprom_tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("MISMATCH %s exp %h got %h", nm, exp, got); \
    end \
  end

module ees_eeprom_tb;
  localparam int PROG = 2000;
  localparam int LIMIT = 90000;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wp = 1'b0;
  logic device_select_bit0 = 1'b0;
  logic device_select_bit1 = 1'b0;
  logic scl_m;
  logic sda_m;
  logic sda_o;
  logic sda_oe;
  logic prog_busy;
  wire logic sda;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;

  always #5 clk = ~clk;
  // pull-up wire: low when either party pulls
  assign sda = sda_m & ~(sda_oe & ~sda_o);

  ees_eeprom #(.PROG_CYCLES(PROG)) dut (
    .clk(clk), .rst_b(rst_b), .scl_i(scl_m), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp),
    .device_select_bit0(device_select_bit0),
    .device_select_bit1(device_select_bit1), .prog_busy(prog_busy)
  );

  ees_master m (.clk(clk), .sda(sda), .scl_m(scl_m), .sda_m(sda_m));

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic addr_hdr(input logic [15:0] a);
    logic ack;
    m.start();
    m.send(8'ha0, ack);
    `CHK("dev ack", 1'b1, ack)
    m.send(a[15:8], ack);
    `CHK("hi ack", 1'b1, ack)
    m.send(a[7:0], ack);
    `CHK("lo ack", 1'b1, ack)
  endtask

  // dummy write then repeated start for read
  task automatic rd_start(input logic [15:0] a);
    logic ack;
    addr_hdr(a);
    m.start();
    m.send(8'ha1, ack);
    `CHK("rd ack", 1'b1, ack)
  endtask

  task automatic wait_prog();
    logic ack;
    int n;
    n = 0;
    `CHK("busy", 1'b1, prog_busy)
    m.start();
    m.send(8'ha0, ack);
    `CHK("poll busy", 1'b0, ack)
    m.stop();
    while (prog_busy === 1'b1 && n < PROG + 10) begin
      @(posedge clk);
      n++;
    end
    `CHK("prog end", 1'b1, n < PROG)
    m.start();
    m.send(8'ha0, ack);
    `CHK("poll done", 1'b1, ack)
    m.stop();
  endtask

  task automatic t_byte();
    logic ack;
    logic [7:0] d;
    addr_hdr(16'h8000);
    m.send(8'ha5, ack);
    `CHK("data ack", 1'b1, ack)
    m.stop();
    wait_prog();
    rd_start(16'h0000);
    m.recv(1'b0, d);
    `CHK("top bit", 8'ha5, d)
    m.stop();
  endtask

  task automatic t_wrap_end();
    logic ack;
    logic [7:0] d;
    addr_hdr(16'h7fff);
    m.send(8'h3c, ack);
    `CHK("data ack", 1'b1, ack)
    m.stop();
    wait_prog();
    rd_start(16'h7fff);
    m.recv(1'b1, d);
    `CHK("last loc", 8'h3c, d)
    m.recv(1'b0, d);
    `CHK("wrap loc", 8'ha5, d)
    m.stop();
  endtask

  task automatic t_page();
    logic ack;
    logic [7:0] d;
    int i;
    addr_hdr(16'h017e);
    for (i = 0; i < 66; i++) begin
      m.send(8'(i) + 8'h10, ack);
      `CHK("page ack", 1'b1, ack)
    end
    m.stop();
    wait_prog();
    rd_start(16'h0140);
    for (int s = 0; s < 64; s++) begin
      m.recv(s < 63, d);
      i = (s + 2) % 64;
      if (i < 2) begin
        i += 64;
      end
      `CHK("page slot", 8'(i) + 8'h10, d)
    end
    m.stop();
  endtask

  task automatic t_protect();
    logic ack;
    logic [7:0] d;
    wp <= 1'b1;
    addr_hdr(16'h0000);
    m.send(8'h77, ack);
    `CHK("wp nack", 1'b0, ack)
    m.stop();
    repeat (20) @(posedge clk);
    `CHK("wp idle", 1'b0, prog_busy)
    wp <= 1'b0;
    rd_start(16'h0000);
    m.recv(1'b0, d);
    `CHK("wp kept", 8'ha5, d)
    m.stop();
  endtask

  task automatic t_select();
    logic ack;
    m.start();
    m.send(8'hb0, ack);
    `CHK("bad code", 1'b0, ack)
    m.stop();
    for (int k = 0; k < 4; k++) begin
      {device_select_bit1, device_select_bit0} <= 2'(k);
      repeat (8) @(posedge clk);
      for (int j = 0; j < 4; j++) begin
        m.start();
        m.send({5'h14, 2'(j), 1'b0}, ack);
        `CHK("select", j == k, ack)
        m.stop();
      end
    end
    {device_select_bit1, device_select_bit0} <= 2'h0;
    repeat (8) @(posedge clk);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    // settle time before the first operation
    repeat (20) @(posedge clk);
    t_select();
    t_byte();
    t_wrap_end();
    t_page();
    t_protect();
    stop_test();
  end
endmodule

`default_nettype wire
